// ### hdl/cra_pkg.sv
// Package for the coefficient RAM block addressing logic
package cra_pkg;
  localparam int WORDS = 40;
  localparam int BLOCKS = 5;
  localparam int BLOCK_WORDS = 8;
  localparam int COEF_W = 16;
  localparam logic [2:0] BLK_IMPEDANCE = 3'h0;
  localparam logic [2:0] BLK_ECHO = 3'h1;
  localparam logic [2:0] BLK_TONE = 3'h2;
  localparam logic [2:0] BLK_TRANSMIT = 3'h3;
  localparam logic [2:0] BLK_RECEIVE = 3'h4;
  localparam logic [2:0] LOW_FIRST = 3'h7;
  localparam logic [2:0] LOW_LAST = 3'h0;
  localparam logic [5:0] TONE0_FREQ_ADDR = 6'h14;
  localparam logic [5:0] TONE0_AMP_ADDR = 6'h15;
  localparam logic [5:0] TONE1_FREQ_ADDR = 6'h16;
  localparam logic [5:0] TONE1_AMP_ADDR = 6'h17;
  localparam logic [5:0] SCALING_BASE = 6'h10;
  localparam logic [5:0] RX_GAIN_BASE = 6'h24;
  localparam logic [5:0] RX_FREQ_BASE = 6'h20;
  localparam logic [COEF_W-1:0] COEF_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] block;
  } cra_cmd_t;

  typedef struct packed {
    logic valid;
    logic [COEF_W-1:0] data;
  } cra_word_t;

  typedef struct packed {
    logic [COEF_W-1:0] tone0Freq;
    logic [COEF_W-1:0] tone0Amp;
    logic [COEF_W-1:0] tone1Freq;
    logic [COEF_W-1:0] tone1Amp;
  } cra_tone_t;
endpackage

// ### hdl/cra_block_addr.sv
// Coefficient RAM with block addressing and automatic down-counting
`timescale 1ns/1ps

module cra_block_addr #(
  parameter int CW = cra_pkg::COEF_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire cra_pkg::cra_cmd_t cmdIn,
  input wire cra_pkg::cra_word_t wrIn,
  output cra_pkg::cra_word_t rdOut,
  output logic busy,
  output logic [5:0] wordAddr,
  output cra_pkg::cra_tone_t toneCoeffs,
  output logic [4*CW-1:0] scaling_gain_coeffs,
  output logic [4*CW-1:0] receive_gain_coeffs,
  output logic [4*CW-1:0] receive_freq_response_coeffs
);
  import cra_pkg::*;

  typedef enum logic [1:0] {IDLE, WRITE_WALK, READ_WALK} cra_state_t;

  function automatic logic blockValid(input logic [2:0] blk);
    blockValid = blk <= BLK_RECEIVE;
  endfunction

  function automatic logic [4*CW-1:0] group4(input logic [CW-1:0] m [WORDS],
                                             input logic [5:0] base);
    logic [4*CW-1:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*CW +: CW] = m[base + 6'(i)];
    end
    group4 = r;
  endfunction

  // --------------------------------------------------
  // Walk control
  // --------------------------------------------------
  cra_state_t state_q, state_d;
  logic [2:0] blk_q, blk_d;
  logic [2:0] low_q, low_d;
  logic [CW-1:0] mem_q [WORDS];
  logic [CW-1:0] mem_d [WORDS];
  cra_word_t rd_q, rd_d;
  logic [5:0] addr;

  assign addr = {blk_q, low_q};

  always_comb begin
    state_d = state_q;
    blk_d = blk_q;
    low_d = low_q;
    mem_d = mem_q;
    rd_d = '0;
    unique case (state_q)
      IDLE: begin
        if (cmdIn.valid && blockValid(cmdIn.block)) begin
          blk_d = cmdIn.block;
          low_d = LOW_FIRST;
          state_d = cmdIn.write ? WRITE_WALK : READ_WALK;
        end
      end
      WRITE_WALK: begin
        if (wrIn.valid) begin
          mem_d[addr] = wrIn.data;
          low_d = low_q - 3'h1;
          if (low_q == LOW_LAST) begin
            state_d = IDLE;
          end
        end
      end
      READ_WALK: begin
        rd_d.valid = 1'b1;
        rd_d.data = mem_q[addr];
        low_d = low_q - 3'h1;
        if (low_q == LOW_LAST) begin
          state_d = IDLE;
        end
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
      blk_q <= BLK_IMPEDANCE;
      low_q <= LOW_FIRST;
      rd_q <= '0;
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= COEF_RESET;
      end
    end else begin
      state_q <= state_d;
      blk_q <= blk_d;
      low_q <= low_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end

  // --------------------------------------------------
  // Coefficient outputs
  // --------------------------------------------------
  cra_tone_t tone_q, tone_d;
  logic [4*CW-1:0] sc_q, sc_d, rg_q, rg_d, rf_q, rf_d;
  logic busy_q, busy_d;
  logic [5:0] wa_q, wa_d;

  always_comb begin
    tone_d.tone0Freq = mem_d[TONE0_FREQ_ADDR];
    tone_d.tone0Amp = mem_d[TONE0_AMP_ADDR];
    tone_d.tone1Freq = mem_d[TONE1_FREQ_ADDR];
    tone_d.tone1Amp = mem_d[TONE1_AMP_ADDR];
    sc_d = group4(mem_d, SCALING_BASE);
    rg_d = group4(mem_d, RX_GAIN_BASE);
    rf_d = group4(mem_d, RX_FREQ_BASE);
    busy_d = state_d != IDLE;
    wa_d = {blk_d, low_d};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tone_q <= '0;
      sc_q <= '0;
      rg_q <= '0;
      rf_q <= '0;
      busy_q <= 1'b0;
      wa_q <= '0;
    end else begin
      tone_q <= tone_d;
      sc_q <= sc_d;
      rg_q <= rg_d;
      rf_q <= rf_d;
      busy_q <= busy_d;
      wa_q <= wa_d;
    end
  end

  assign rdOut = rd_q;
  assign busy = busy_q;
  assign wordAddr = wa_q;
  assign toneCoeffs = tone_q;
  assign scaling_gain_coeffs = sc_q;
  assign receive_gain_coeffs = rg_q;
  assign receive_freq_response_coeffs = rf_q;

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  sequence s_start;
    state_q == IDLE && cmdIn.valid && blockValid(cmdIn.block);
  endsequence

  property p_start_high;
    @(posedge core_clk) disable iff (!resetn)
      s_start |=> low_q == LOW_FIRST && blk_q == $past(cmdIn.block);
  endproperty
  a_start_high: assert property (p_start_high) else $error("walk not at top word");

  property p_read_eight;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == IDLE && cmdIn.valid && !cmdIn.write && blockValid(cmdIn.block))
      |=> rd_d.valid [*8] ##1 state_q == IDLE;
  endproperty
  a_read_eight: assert property (p_read_eight) else $error("read walk not eight words");

  property p_down;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == READ_WALK && low_q != LOW_LAST) |=> low_q == $past(low_q) - 3'h1;
  endproperty
  a_down: assert property (p_down) else $error("low index not decremented");

  property p_addr;
    @(posedge core_clk) disable iff (!resetn)
      state_q != IDLE |-> wa_q == addr && blk_q <= BLK_RECEIVE;
  endproperty
  a_addr: assert property (p_addr) else $error("upper address not block");

  property p_ignore;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == IDLE && cmdIn.valid && !blockValid(cmdIn.block)) |=> state_q == IDLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad block accepted");

  property p_rx_gain;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == WRITE_WALK && wrIn.valid && addr == RX_GAIN_BASE + 6'h3)
      |=> rg_q[4*CW-1 -: CW] == $past(wrIn.data);
  endproperty
  a_rx_gain: assert property (p_rx_gain) else $error("receive gain mismatch");

  property p_rx_freq;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == WRITE_WALK && wrIn.valid && addr == RX_FREQ_BASE + 6'h3)
      |=> rf_q[4*CW-1 -: CW] == $past(wrIn.data);
  endproperty
  a_rx_freq: assert property (p_rx_freq) else $error("receive response mismatch");

  property p_tone;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == WRITE_WALK && wrIn.valid && addr == TONE1_AMP_ADDR)
      |=> tone_q.tone1Amp == $past(wrIn.data);
  endproperty
  a_tone: assert property (p_tone) else $error("tone mismatch");

  property p_scaling;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == WRITE_WALK && wrIn.valid && addr == SCALING_BASE)
      |=> sc_q[CW-1:0] == $past(wrIn.data);
  endproperty
  a_scaling: assert property (p_scaling) else $error("scaling mismatch");

  property p_rx_map;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == WRITE_WALK && wrIn.valid && blk_q != BLK_RECEIVE)
      |=> $stable(rg_q) && $stable(rf_q);
  endproperty
  a_rx_map: assert property (p_rx_map) else $error("receive words hit by other block");

  property p_tone_map;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == WRITE_WALK && wrIn.valid && blk_q != BLK_TONE)
      |=> $stable(tone_q) && $stable(sc_q);
  endproperty
  a_tone_map: assert property (p_tone_map) else $error("tone words hit by other block");

  property p_busy;
    @(posedge core_clk) disable iff (!resetn)
      (state_q == IDLE && cmdIn.valid && !cmdIn.write && blockValid(cmdIn.block))
      |=> busy_q [*8] ##1 !busy_q;
  endproperty
  a_busy: assert property (p_busy) else $error("busy wrong");
endmodule

// ### tb/cra_host_model.sv
// Host model issuing coefficient RAM block commands
`timescale 1ns/1ps
module cra_host_model (
  input wire logic core_clk,
  output cra_pkg::cra_cmd_t cmdIn,
  output cra_pkg::cra_word_t wrIn,
  input wire cra_pkg::cra_word_t rdOut,
  input wire logic busy
);
  import cra_pkg::*;
  initial begin
    cmdIn = '0;
    wrIn = '0;
  end
  // Block only, low bits left to the device
  task automatic walk(input logic wr, input logic [2:0] blk, input logic [COEF_W-1:0] w[8],
                      input int gap, output logic [COEF_W-1:0] got[8], output int n);
    int t;
    n = 0;
    @(posedge core_clk);
    cmdIn <= '{1'b1, wr, blk};
    @(posedge core_clk);
    cmdIn <= '{1'b0, wr, ~blk};
    if (wr) begin
      for (int i = 0; i < 8; i++) begin
        wrIn <= '{1'b1, w[i]};
        @(posedge core_clk);
        if (gap > 0) begin
          wrIn <= '{1'b0, ~w[i]};
          repeat (gap) @(posedge core_clk);
        end
      end
      if (gap == 0) wrIn <= '{1'b0, ~w[7]};
    end else begin
      for (t = 0; t < 20 && n < 8; t++) begin
        @(posedge core_clk);
        if (rdOut.valid === 1'b1) begin
          got[n] = rdOut.data;
          n++;
        end
      end
    end
    for (t = 0; t < 20 && busy !== 1'b0; t++) @(posedge core_clk);
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the coefficient RAM block addressing
`timescale 1ns/1ps
`define CHECK(nm, ex, sn) begin nChecks++; if ((sn) !== (ex)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, sn); end end
module tb_top;
  import cra_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  cra_cmd_t cmdIn;
  cra_word_t wrIn;
  cra_word_t rdOut;
  logic busy;
  logic [5:0] wordAddr;
  cra_tone_t toneCoeffs;
  logic [63:0] scal;
  logic [63:0] rxg;
  logic [63:0] rxf;
  int failures = 0;
  int nChecks = 0;
  int cycles = 0;
  int n;
  logic [COEF_W-1:0] w[8];
  logic [COEF_W-1:0] got[8];
  always #2 core_clk = ~core_clk;
  cra_block_addr dut_u(.core_clk(core_clk), .resetn(resetn), .cmdIn(cmdIn), .wrIn(wrIn),
    .rdOut(rdOut), .busy(busy), .wordAddr(wordAddr), .toneCoeffs(toneCoeffs),
    .scaling_gain_coeffs(scal), .receive_gain_coeffs(rxg), .receive_freq_response_coeffs(rxf));
  cra_host_model host_u(.core_clk(core_clk), .cmdIn(cmdIn), .wrIn(wrIn), .rdOut(rdOut),
    .busy(busy));
  function automatic logic [15:0] wv(int k);
    return 16'hc300 + 16'(k);
  endfunction
  task automatic fill(input int b, input int gap, input int base);
    for (int i = 0; i < 8; i++) w[i] = wv(base + b * 8 + 7 - i);
    host_u.walk(1'b1, 3'(b), w, gap, got, n);
  endtask
  task automatic read_blk(input int b);
    host_u.walk(1'b0, 3'(b), w, 0, got, n);
    `CHECK("count", 8, n)
    for (int i = 0; i < 8; i++) `CHECK("word", wv(b * 8 + 7 - i), got[i])
    `CHECK("addr", {3'(b), LOW_FIRST}, wordAddr)
  endtask
  task automatic test_tone();
    fill(2, 0, 0);
    `CHECK("addr", {BLK_TONE, LOW_FIRST}, wordAddr)
    `CHECK("tone", {wv(20), wv(21), wv(22), wv(23)}, toneCoeffs)
    `CHECK("scal", {wv(19), wv(18), wv(17), wv(16)}, scal)
  endtask
  task automatic test_receive();
    fill(4, 2, 0);
    `CHECK("rxg", {wv(39), wv(38), wv(37), wv(36)}, rxg)
    `CHECK("rxf", {wv(35), wv(34), wv(33), wv(32)}, rxf)
  endtask
  task automatic test_all();
    fill(0, 0, 0);
    fill(1, 1, 0);
    fill(3, 0, 0);
    for (int b = 0; b < 5; b++) read_blk(b);
  endtask
  task automatic test_illegal();
    for (int b = 5; b < 8; b++) begin
      fill(b, 0, 64);
      `CHECK("busy", 1'b0, busy)
      host_u.walk(1'b0, 3'(b), w, 0, got, n);
      `CHECK("none", 0, n)
    end
    `CHECK("rxg", {wv(39), wv(38), wv(37), wv(36)}, rxg)
    `CHECK("addr", {BLK_RECEIVE, LOW_FIRST}, wordAddr)
    read_blk(2);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    test_tone();
    test_receive();
    test_all();
    test_illegal();
    print_verdict();
  end
endmodule
